//--- rtl/rws_regs.svh
// Register offsets, field positions, reset values and timing counts for the reset and wake block.
`ifndef RWS_REGS_SVH
`define RWS_REGS_SVH
`define RWS_OFF_RCC        12'h000
`define RWS_OFF_WAKE       12'h004
`define RWS_OFF_STAT       12'h008
`define RWS_BIT_IPE        7
`define RWS_BIT_SBE        6
`define RWS_BIT_RIF        4
`define RWS_BIT_WDF        3
`define RWS_BIT_SLF        2
`define RWS_BIT_POF        1
`define RWS_BIT_BOF        0
`define RWS_RCC_RST        8'h1c
`define RWS_CLK_MHZ        125
`define RWS_TCSD_NS        10000
`define RWS_TCSD_CYC       ((`RWS_TCSD_NS * `RWS_CLK_MHZ) / 1000)
`define RWS_TOST_CYC       1024
`define RWS_PLL_LOCK_DELAY_US        2000
`define RWS_PLL_LOCK_DELAY_CYC       (`RWS_PLL_LOCK_DELAY_US * `RWS_CLK_MHZ)
`define RWS_TIOB_US        1000
`define RWS_TIOB_CYC       (`RWS_TIOB_US * `RWS_CLK_MHZ)
`define RWS_FILT_CYC       16
`endif

//--- rtl/rws_pkg.sv
// Types shared by the reset and wake block.
package rws_pkg;
    // Clock source categories before and after a wake.
    typedef enum logic [2:0] {
        RWS_SRC_NONE,
        RWS_SRC_PRI_XT,
        RWS_SRC_PRI_PLL,
        RWS_SRC_PRI_OTHER,
        RWS_SRC_SLOW_RC,
        RWS_SRC_FAST_RC,
        RWS_SRC_SEC_XTAL
    } rws_src_e;
    // Wake sequencer states.
    typedef enum logic [1:0] {
        RWS_ST_RUN,
        RWS_ST_WAIT
    } rws_state_e;
    // One-cycle reset and instruction events from the core.
    typedef struct packed {
        logic por;
        logic brownout;
        logic watchdog;
        logic reset_instr;
        logic stack_full;
        logic stack_under;
        logic watchdog_clear_op;
        logic sleep_op;
    } rws_evt_s;
    // APB request group.
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } rws_apb_s;
endpackage

//--- rtl/rws_top.sv
// Reset cause tracking, external reset filter and wake exit delay sequencer.
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "rws_regs.svh"
module rws_top
    import rws_pkg::*;
#(
    parameter int unsigned PLL_LOCK_DELAY_CYC = `RWS_PLL_LOCK_DELAY_CYC,
    parameter int unsigned TIOB_CYC = `RWS_TIOB_CYC
) (
    // Clock and reset.
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    // APB slave.
    input  wire rws_pkg::rws_apb_s apb_i,
    output logic [31:0]        prdata_o,
    output logic               pready_o,
    output logic               pslverr_o,
    // Configuration straps.
    input  wire logic [1:0]    brownout_mode_cfg_i,
    input  wire logic          ext_reset_pin_enable_i,
    // Core events and supply monitor.
    input  wire rws_pkg::rws_evt_s evt_i,
    input  wire logic          supply_low_i,
    input  wire logic          sleep_mode_i,
    // Wake request and clock sources.
    input  wire logic          wake_i,
    input  wire rws_pkg::rws_src_e src_before_i,
    input  wire rws_pkg::rws_src_e src_after_i,
    // External reset pin.
    input  wire logic          ext_reset_pin_i,
    output logic               ext_reset_pin_o,
    output logic               ext_reset_pin_oe_o,
    // Results.
    output logic               sys_reset_o,
    output logic               pin_input_o,
    output logic               cpu_stall_o,
    output logic               primary_clock_ready_o,
    output logic               fast_rc_stable_o,
    output logic               irq_priority_enable_o,
    output logic               brownout_active_o
);
    import rws_pkg::*;

    localparam int unsigned TCSD_CYC = `RWS_TCSD_CYC;
    localparam int unsigned TOST_CYC = `RWS_TOST_CYC;

    // Saturating decrement used by every delay counter.
    function automatic logic [31:0] dec_sat(input logic [31:0] v);
        dec_sat = (v == 32'h0) ? 32'h0 : v - 32'h1;
    endfunction

    // Pin synchroniser and filter state.
    logic        pin_s1_q, pin_s2_q;
    logic [4:0]  filt_q, filt_d;
    logic        pin_rst_q, pin_rst_d;
    logic        pin_in_q, pin_in_d;
    // Reset control register and brownout hold.
    logic [7:0]  rcc_q, rcc_d;
    logic        bor_hold_q, bor_hold_d;
    logic        sys_rst_q, sys_rst_d;
    logic        cfg_seen_q;
    // Wake sequencer.
    rws_state_e  st_q, st_d;
    logic [31:0] cpu_cnt_q, cpu_cnt_d;
    logic [31:0] clk_cnt_q, clk_cnt_d;
    logic [31:0] rc_cnt_q, rc_cnt_d;
    logic        pri_rdy_q, pri_rdy_d;
    logic        rc_ok_q, rc_ok_d;
    logic        stall_q, stall_d;
    // Bus answer.
    logic [31:0] rdata_q, rdata_d;
    logic        rdy_q, rdy_d;
    logic        err_q, err_d;

    logic        sw_mode;
    logic        bor_en;
    logic        acc;
    logic        wr;
    assign sw_mode = (brownout_mode_cfg_i == 2'b01);
    // Mode 10 drops brownout protection while sleeping.
    assign bor_en = sw_mode ? rcc_q[`RWS_BIT_SBE] :
                    (brownout_mode_cfg_i == 2'b11) ||
                    ((brownout_mode_cfg_i == 2'b10) && !sleep_mode_i);
    assign acc = apb_i.psel && apb_i.penable && !rdy_q;
    // A write lands only at the edge that sees pready high, where the master completes it.
    assign wr  = apb_i.psel && apb_i.penable && rdy_q && apb_i.pwrite;

    // Two flip-flop synchroniser on the pin; nothing else reads the first stage.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
        end else begin
            pin_s1_q <= ext_reset_pin_i;
            pin_s2_q <= pin_s1_q;
        end
    end

    // Filter counts consecutive low samples; a high sample restarts it.
    always_comb begin
        filt_d    = filt_q;
        pin_rst_d = 1'b0;
        pin_in_d  = pin_s2_q;
        if (!ext_reset_pin_enable_i) begin
            filt_d = 5'h0;
        end else if (pin_s2_q) begin
            filt_d = 5'h0;
        end else if (filt_q == 5'(`RWS_FILT_CYC)) begin
            pin_rst_d = 1'b1;
        end else begin
            filt_d = filt_q + 5'h1;
        end
    end

    // Filter registers.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            filt_q    <= 5'h0;
            pin_rst_q <= 1'b0;
            pin_in_q  <= 1'b1;
        end else begin
            filt_q    <= filt_d;
            pin_rst_q <= pin_rst_d;
            pin_in_q  <= pin_in_d;
        end
    end

    // Reset control register: hardware events win over a same-cycle write.
    always_comb begin
        rcc_d      = rcc_q;
        bor_hold_d = bor_hold_q;
        if (wr && apb_i.paddr == `RWS_OFF_RCC) begin
            rcc_d[`RWS_BIT_IPE] = apb_i.pwdata[`RWS_BIT_IPE];
            rcc_d[`RWS_BIT_SBE] = sw_mode & apb_i.pwdata[`RWS_BIT_SBE];
            rcc_d[`RWS_BIT_RIF] = apb_i.pwdata[`RWS_BIT_RIF];
            rcc_d[`RWS_BIT_POF] = apb_i.pwdata[`RWS_BIT_POF];
            rcc_d[`RWS_BIT_BOF] = apb_i.pwdata[`RWS_BIT_BOF];
        end
        if (evt_i.watchdog_clear_op || evt_i.sleep_op) begin
            rcc_d[`RWS_BIT_WDF] = 1'b1;
        end
        if (evt_i.watchdog) begin
            rcc_d[`RWS_BIT_WDF] = 1'b0;
        end
        if (evt_i.watchdog_clear_op) begin
            rcc_d[`RWS_BIT_SLF] = 1'b1;
        end
        if (evt_i.sleep_op) begin
            rcc_d[`RWS_BIT_SLF] = 1'b0;
        end
        if (evt_i.reset_instr) begin
            rcc_d[`RWS_BIT_RIF] = 1'b0;
        end
        if (bor_en && supply_low_i) begin
            bor_hold_d = 1'b1;
        end else if (!supply_low_i) begin
            bor_hold_d = 1'b0;
        end
        if (evt_i.brownout && bor_en) begin
            rcc_d[`RWS_BIT_BOF] = 1'b0;
        end
        if (evt_i.por) begin
            rcc_d[`RWS_BIT_POF] = 1'b0;
            rcc_d[`RWS_BIT_WDF] = 1'b1;
            rcc_d[`RWS_BIT_SLF] = 1'b1;
            rcc_d[`RWS_BIT_BOF] = 1'b0;
        end
        rcc_d[5] = 1'b0;
        if (!sw_mode) begin
            rcc_d[`RWS_BIT_SBE] = 1'b0;
        end
    end

    always_comb begin
        sys_rst_d = evt_i.por | bor_hold_q | pin_rst_q | evt_i.watchdog
                  | evt_i.reset_instr | evt_i.stack_full | evt_i.stack_under;
    end

    // Registers; software enable default is caught once after reset release.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rcc_q      <= `RWS_RCC_RST;
            bor_hold_q <= 1'b0;
            sys_rst_q  <= 1'b1;
            cfg_seen_q <= 1'b0;
        end else begin
            rcc_q      <= rcc_d;
            bor_hold_q <= bor_hold_d;
            sys_rst_q  <= sys_rst_d;
            cfg_seen_q <= 1'b1;
            // enable resets one in mode 01
            if (!cfg_seen_q) begin
                rcc_q[`RWS_BIT_SBE] <= sw_mode;
            end
        end
    end

    // Wake sequencer: the CPU delay loads on every wake, the clock and fast RC delays only on a matching source change; all count in parallel.
    always_comb begin
        st_d      = st_q;
        cpu_cnt_d = dec_sat(cpu_cnt_q);
        clk_cnt_d = dec_sat(clk_cnt_q);
        rc_cnt_d  = dec_sat(rc_cnt_q);
        pri_rdy_d = pri_rdy_q;
        rc_ok_d   = rc_ok_q;
        stall_d   = stall_q;
        // Fast RC settle never stalls the CPU.
        if (!rc_ok_q && rc_cnt_q == 32'h1) begin
            rc_ok_d = 1'b1;
        end
        case (st_q)
            RWS_ST_RUN: begin
                if (wake_i) begin
                    st_d    = RWS_ST_WAIT;
                    stall_d = 1'b1;
                    cpu_cnt_d = TCSD_CYC;
                    if ((src_after_i == RWS_SRC_PRI_XT || src_after_i == RWS_SRC_PRI_PLL)
                        && src_before_i != RWS_SRC_PRI_XT
                        && src_before_i != RWS_SRC_PRI_PLL) begin
                        clk_cnt_d = TOST_CYC
                                  + ((src_after_i == RWS_SRC_PRI_PLL) ? PLL_LOCK_DELAY_CYC : 32'h0);
                        pri_rdy_d = 1'b0;
                    end
                    // no extra when already fast RC
                    if (src_after_i == RWS_SRC_FAST_RC && src_before_i != RWS_SRC_FAST_RC) begin
                        rc_cnt_d = TIOB_CYC;
                        rc_ok_d  = 1'b0;
                    end
                end
            end
            RWS_ST_WAIT: begin
                if (clk_cnt_q == 32'h1) begin
                    pri_rdy_d = 1'b1;
                end
                if (cpu_cnt_q <= 32'h1 && clk_cnt_q <= 32'h1) begin
                    st_d    = RWS_ST_RUN;
                    stall_d = 1'b0;
                end
            end
            default: begin
                st_d    = RWS_ST_RUN;
                stall_d = 1'b0;
            end
        endcase
    end

    // Sequencer registers.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q      <= RWS_ST_RUN;
            cpu_cnt_q <= 32'h0;
            clk_cnt_q <= 32'h0;
            rc_cnt_q  <= 32'h0;
            pri_rdy_q <= 1'b1;
            rc_ok_q   <= 1'b1;
            stall_q   <= 1'b0;
        end else begin
            st_q      <= st_d;
            cpu_cnt_q <= cpu_cnt_d;
            clk_cnt_q <= clk_cnt_d;
            rc_cnt_q  <= rc_cnt_d;
            pri_rdy_q <= pri_rdy_d;
            rc_ok_q   <= rc_ok_d;
            stall_q   <= stall_d;
        end
    end

    // APB answer: one wait state, then pready for one cycle.
    always_comb begin
        rdy_d   = acc;
        err_d   = 1'b0;
        rdata_d = 32'h0;
        if (acc) begin
            case (apb_i.paddr)
                `RWS_OFF_RCC:  rdata_d = {24'h0, rcc_q};
                `RWS_OFF_WAKE: rdata_d = {29'h0, rc_ok_q, pri_rdy_q, stall_q};
                `RWS_OFF_STAT: rdata_d = {28'h0, bor_hold_q, pin_rst_q, pin_in_q, bor_en};
                default:       err_d = 1'b1;
            endcase
        end
    end

    // Bus answer registers.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= 32'h0;
            rdy_q   <= 1'b0;
            err_q   <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rdy_q   <= rdy_d;
            err_q   <= err_d;
        end
    end

    assign ext_reset_pin_o       = 1'b0;
    assign ext_reset_pin_oe_o    = 1'b0;
    assign prdata_o              = rdata_q;
    assign pready_o              = rdy_q;
    assign pslverr_o             = err_q;
    assign sys_reset_o           = sys_rst_q;
    assign pin_input_o           = pin_in_q;
    assign cpu_stall_o           = stall_q;
    assign primary_clock_ready_o = pri_rdy_q;
    assign fast_rc_stable_o      = rc_ok_q;
    assign irq_priority_enable_o = rcc_q[`RWS_BIT_IPE];
    assign brownout_active_o     = bor_hold_q;
endmodule
`default_nettype wire

//--- dv/rws_top_sva.sv
// Port-level assertion checker for the reset and wake block.
`timescale 1ns/10ps
`default_nettype none
module rws_top_sva
    import rws_pkg::*;
#(
    parameter int unsigned PLL_LOCK_DELAY_CYC = 20
) (
    // Clock and reset.
    input wire logic              clk_i,
    input wire logic              rst_i,
    // Bus side.
    input wire rws_pkg::rws_apb_s apb_i,
    input wire logic [31:0]       prdata_o,
    input wire logic              pready_o,
    input wire logic              pslverr_o,
    // Straps, wake and pin.
    input wire logic [1:0]        brownout_mode_cfg_i,
    input wire logic              ext_reset_pin_enable_i,
    input wire rws_pkg::rws_evt_s evt_i,
    input wire logic              wake_i,
    input wire logic              ext_reset_pin_i,
    input wire logic              ext_reset_pin_o,
    input wire logic              ext_reset_pin_oe_o,
    // Results.
    input wire logic              sys_reset_o,
    input wire logic              cpu_stall_o,
    input wire logic              primary_clock_ready_o,
    input wire logic              irq_priority_enable_o,
    input wire logic              brownout_active_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [15:0] low_q;   // Consecutive low samples of the raw pin.
    logic [15:0] low_d;
    logic [31:0] stall_q; // Cycles the CPU has been stalled so far.
    logic [31:0] stall_d;
    // Next counts; the low counter saturates so a long hold never wraps back under the filter.
    always_comb begin
        low_d = ext_reset_pin_i ? 16'h0 : low_q + {15'h0, low_q != 16'hffff};
        stall_d = cpu_stall_o ? stall_q + 32'h1 : 32'h0;
    end
    // Register the helper counts.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            low_q <= 16'h0;
            stall_q <= 32'h0;
        end else begin
            low_q <= low_d;
            stall_q <= stall_d;
        end
    end
    a_pin_undriven: assert property (!ext_reset_pin_oe_o && !ext_reset_pin_o)
        else $error("reset pin driven");
    a_apb_answer: assert property (apb_i.psel && apb_i.penable && !pready_o |=> pready_o)
        else $error("no answer one cycle after access");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    a_unmapped_err: assert property (pready_o && apb_i.paddr > 12'h008
        |-> pslverr_o && prdata_o == 32'h0) else $error("unmapped access accepted");
    a_ctrl_readback: assert property (pready_o && !apb_i.pwrite && apb_i.paddr == 12'h000
        |-> prdata_o[7] == irq_priority_enable_o && !prdata_o[5]
        && (brownout_mode_cfg_i == 2'b01 || !prdata_o[6])) else $error("control readback wrong");
    a_stall_start: assert property (wake_i && !cpu_stall_o |=> cpu_stall_o)
        else $error("wake did not stall");
    a_stall_length: assert property ($fell(cpu_stall_o) |-> stall_q >= 32'd1248
        && stall_q <= 32'd1254 + PLL_LOCK_DELAY_CYC) else $error("stall length wrong");
    a_ready_drop: assert property ($fell(primary_clock_ready_o) |-> cpu_stall_o)
        else $error("clock ready dropped outside a wake");
    a_filter_len: assert property ($rose(sys_reset_o) && !brownout_active_o
        && $past(evt_i) == 8'h00 |-> ext_reset_pin_enable_i && low_q >= 16'd16)
        else $error("pin reset too early");
    a_bo_off: assert property (brownout_mode_cfg_i == 2'b00 |=> !brownout_active_o)
        else $error("brown-out hold while disabled");
endmodule
bind rws_top rws_top_sva #(.PLL_LOCK_DELAY_CYC(PLL_LOCK_DELAY_CYC)) i_sva (.clk_i(clk_i), .rst_i(rst_i),
    .apb_i(apb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .brownout_mode_cfg_i(brownout_mode_cfg_i), .ext_reset_pin_enable_i(ext_reset_pin_enable_i),
    .wake_i(wake_i), .ext_reset_pin_i(ext_reset_pin_i), .ext_reset_pin_o(ext_reset_pin_o),
    .ext_reset_pin_oe_o(ext_reset_pin_oe_o), .sys_reset_o(sys_reset_o),
    .cpu_stall_o(cpu_stall_o), .primary_clock_ready_o(primary_clock_ready_o), .evt_i(evt_i),
    .irq_priority_enable_o(irq_priority_enable_o), .brownout_active_o(brownout_active_o));
`default_nettype wire

//--- dv/reset_and_wake_status_bench.sv
// Self-checking bench for the reset and wake block.
`timescale 1ns/10ps
`default_nettype none
`include "rws_regs.svh"
module reset_and_wake_status_bench;
    import rws_pkg::*;
    localparam int unsigned PLL_LOCK_DELAY = 500; // Long enough to outlast the fixed CPU-ready delay.
    localparam int TCSD = `RWS_TCSD_CYC;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    rws_apb_s apb = '0;
    rws_evt_s evt = '0; // Bit order: por brownout watchdog rinstr sfull sunder watchdog_clear_op sleep.
    logic [1:0] mode = 2'b01;
    logic pin_en = 1'b1, supply_low = 1'b0, wake = 1'b0, pin = 1'b1, sleep_mode = 1'b0;
    rws_src_e src_b = RWS_SRC_NONE, src_a = RWS_SRC_NONE;
    logic [31:0] prdata;
    logic pready, pslverr, pin_o, pin_oe, sys_rst, pin_in, stall, pri_rdy, frc_rdy, ipe, bo_act;
    int miscompares = 0, checked = 0, cycles = 0;
    rws_top #(.PLL_LOCK_DELAY_CYC(PLL_LOCK_DELAY), .TIOB_CYC(20)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
        .apb_i(apb), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .brownout_mode_cfg_i(mode), .ext_reset_pin_enable_i(pin_en), .evt_i(evt),
        .supply_low_i(supply_low), .sleep_mode_i(sleep_mode), .wake_i(wake), .src_before_i(src_b),
        .src_after_i(src_a), .ext_reset_pin_i(pin), .ext_reset_pin_o(pin_o),
        .ext_reset_pin_oe_o(pin_oe), .sys_reset_o(sys_rst), .pin_input_o(pin_in),
        .cpu_stall_o(stall), .primary_clock_ready_o(pri_rdy), .fast_rc_stable_o(frc_rdy),
        .irq_priority_enable_o(ipe), .brownout_active_o(bo_act));
    always #4 clk_i = ~clk_i;
    // A hang is cut short well beyond the longest expected run.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            test_done();
        end
    end
    task automatic test_done();
        $display("miscompares %0d checked %0d", miscompares, checked);
        if (miscompares == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %0t: value 0x%h, expected 0x%h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        cmp_reg({31'h0, got}, {31'h0, exp});
    endtask
    task automatic cmp_cnt(input int got, input int lo, input int hi);
        checked++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("Error %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask
    // One APB transfer; pready and the answer are taken at the rising edge, before it updates them.
    task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                            output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge clk_i);
        apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge clk_i);
        apb.penable <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        if (n >= 20) cmp_bit(1'b0, 1'b1);
        apb <= '0;
    endtask
    task automatic wr(input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb_xfer(1'b1, `RWS_OFF_RCC, d, r, e);
    endtask
    task automatic rd_chk(input logic [7:0] mask, input logic [7:0] exp);
        logic [31:0] r;
        logic e;
        apb_xfer(1'b0, `RWS_OFF_RCC, 32'h0, r, e);
        cmp_reg(r & {24'h0, mask}, {24'h0, exp});
    endtask
    task automatic pulse(input logic [7:0] e, input logic [7:0] mask, input logic [7:0] exp);
        @(posedge clk_i);
        evt <= rws_evt_s'(e);
        @(posedge clk_i);
        evt <= '0;
        rd_chk(mask, exp);
    endtask
    // Reset values, access kinds, unmapped access and the mode-gated enable.
    task automatic t_regs();
        logic [31:0] r;
        logic e;
        rd_chk(8'hff, 8'h5c);
        wr(32'hff);
        rd_chk(8'hff, 8'hdf);
        cmp_bit(ipe, 1'b1);
        apb_xfer(1'b0, 12'h00c, 32'h0, r, e);
        cmp_reg(r, 32'h0);
        cmp_bit(e, 1'b1);
        wr(32'h0);
        rd_chk(8'hff, 8'h0c);
        mode <= 2'b00;
        supply_low <= 1'b1;
        wr(32'h40);
        rd_chk(8'hff, 8'h0c);
        cmp_bit(bo_act, 1'b0);
        mode <= 2'b01;
        supply_low <= 1'b0;
        wr(32'h40);
        rd_chk(8'hff, 8'h4c);
    endtask
    // Each event moves only its own flags.
    task automatic t_events();
        wr(32'hff);
        pulse(8'h10, 8'hff, 8'hcf);
        pulse(8'h20, 8'hff, 8'hc7);
        pulse(8'h02, 8'hff, 8'hcf);
        pulse(8'h01, 8'hff, 8'hcb);
        pulse(8'h40, 8'h03, 8'h02);
        pulse(8'h0c, 8'hff, 8'hca);
        wr(32'hff);
        pulse(8'h80, 8'h1f, 8'h1c);
        wr(32'hff);
        rd_chk(8'h03, 8'h03);
    endtask
    // Wake and count stall cycles, noting any drop of the two ready flags.
    task automatic wake_one(input rws_src_e b, input rws_src_e a, input int len,
                            input logic pri_dip, input logic frc_dip);
        int n;
        logic pr;
        logic fr;
        n = 0;
        pr = 1'b1;
        fr = 1'b1;
        @(posedge clk_i);
        src_b <= b;
        src_a <= a;
        wake <= 1'b1;
        @(posedge clk_i);
        wake <= 1'b0;
        for (int g = 0; g < 3000 && (n == 0 || stall === 1'b1); g++) begin
            @(negedge clk_i);
            n += int'(stall === 1'b1);
            pr &= pri_rdy;
            fr &= frc_rdy;
        end
        repeat (40) @(negedge clk_i);
        cmp_cnt(n, len - 1, len + 2);
        cmp_bit(pr, !pri_dip);
        cmp_bit(fr, !frc_dip);
        cmp_bit(pri_rdy & frc_rdy, 1'b1);
    endtask
    task automatic t_wake();
        wake_one(RWS_SRC_PRI_XT, RWS_SRC_PRI_XT, TCSD, 1'b0, 1'b0);
        wake_one(RWS_SRC_SLOW_RC, RWS_SRC_PRI_XT, TCSD, 1'b1, 1'b0);
        wake_one(RWS_SRC_NONE, RWS_SRC_PRI_PLL, `RWS_TOST_CYC + PLL_LOCK_DELAY, 1'b1, 1'b0);
        wake_one(RWS_SRC_SEC_XTAL, RWS_SRC_PRI_OTHER, TCSD, 1'b0, 1'b0);
        wake_one(RWS_SRC_SLOW_RC, RWS_SRC_FAST_RC, TCSD, 1'b0, 1'b1);
        wake_one(RWS_SRC_FAST_RC, RWS_SRC_FAST_RC, TCSD, 1'b0, 1'b0);
    endtask
    // Hold the pin low for a number of cycles; report any reset and the input level seen.
    task automatic pin_low(input int cyc, output logic seen, output logic lvl);
        seen = 1'b0;
        lvl = 1'b1;
        for (int i = 0; i < cyc + 8; i++) begin
            @(posedge clk_i);
            pin <= (i >= cyc);
            @(negedge clk_i);
            seen |= (sys_rst === 1'b1);
            if (i == cyc - 1) lvl = pin_in;
        end
    endtask
    task automatic t_pin();
        logic s;
        logic l;
        cmp_bit(sys_rst, 1'b0);
        pin_low(15, s, l);
        cmp_bit(s, 1'b0);
        pin_low(20, s, l);
        cmp_bit(s, 1'b1);
        cmp_bit(sys_rst, 1'b0);
        pin_en <= 1'b0;
        pin_low(30, s, l);
        cmp_bit(s, 1'b0);
        cmp_bit(l, 1'b0);
        cmp_bit(pin_in, 1'b1);
    endtask
    // Hardware brown-out modes, sleep gating and the two status words.
    task automatic t_bo();
        logic [31:0] r;
        logic e;
        apb_xfer(1'b0, `RWS_OFF_WAKE, 32'h0, r, e);
        cmp_reg(r, 32'h6);
        mode <= 2'b11;
        supply_low <= 1'b1;
        repeat (3) @(posedge clk_i);
        cmp_bit(sys_rst, 1'b1);
        apb_xfer(1'b0, `RWS_OFF_STAT, 32'h0, r, e);
        cmp_reg(r, 32'hb);
        mode <= 2'b10;
        sleep_mode <= 1'b1;
        supply_low <= 1'b0;
        repeat (3) @(posedge clk_i);
        supply_low <= 1'b1;
        repeat (3) @(posedge clk_i);
        cmp_bit(sys_rst, 1'b0);
        apb_xfer(1'b0, `RWS_OFF_STAT, 32'h0, r, e);
        cmp_reg(r, 32'h2);
        sleep_mode <= 1'b0;
        repeat (3) @(posedge clk_i);
        cmp_bit(bo_act, 1'b1);
        supply_low <= 1'b0;
        mode <= 2'b01;
    endtask
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        t_regs();
        t_events();
        t_wake();
        t_pin();
        t_bo();
        test_done();
    end
endmodule
`default_nettype wire
